//--- shared/rcps_pkg.sv
package rcps_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] REFCLK_CTRL_OFS = 12'h000;
	localparam logic [11:0] PS_CTRL_OFS     = 12'h004;
	localparam logic [11:0] PS_STATUS_OFS   = 12'h008;

	localparam int REF_OUTPUT_ENABLE_BIT  = 15;
	localparam int RSLP_BIT  = 13;
	localparam int RSEL_BIT  = 12;
	localparam int RDIV_LSB  = 8;
	localparam logic [15:0] REFCLK_CTRL_RST  = 16'h0000;
	localparam logic [15:0] REFCLK_CTRL_MASK = 16'hBF00;

	// power-save control register fields
	localparam int PSC_WDT_EN_BIT  = 0;
	localparam int PSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT = 1;
	localparam int PSC_KEEP_PO_BIT = 2;
	localparam logic [2:0] PS_CTRL_RST = 3'h0;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// power-save instruction operand
	localparam logic PS_OP_SLEEP = 1'b0;
	localparam logic PS_OP_IDLE  = 1'b1;

	typedef enum logic [1:0] {
		PS_RUN   = 2'b00,
		PS_ENTER = 2'b01,
		PS_LOW   = 2'b11,
		PS_WAKE  = 2'b10
	} rcps_ps_state_t;

	typedef struct packed {
		logic run_clk_en;
		logic osc_on;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic fail_safe_clock_monitor_active;
		logic low_power_rc_osc_on;
		logic wdt_clear;
		logic in_sleep;
		logic in_idle;
	} rcps_clk_ctl_t;

endpackage

//--- src/rcps_top.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: reference pin drives divided clock only while output enable bit 15 is set.
// R2: divisor field divides base clock by two to the field value; code 0 here divides by two, the same as code 1.
// R3: source select 1 uses primary oscillator, 0 uses system clock.
// R4: run-in-sleep 1 keeps output running in sleep, 0 stops it.
// R5: software sets run-in-sleep, source select and keep-primary for sleep output.
// R6: bit 14 and low byte ignore writes and read as zero.
// R7: power-save instruction enters sleep or idle chosen by operand.
// R8: sleep shuts down the system clock source oscillator.
// R9: fail-safe clock monitor inactive throughout sleep.
// R10: low-power rc oscillator runs in sleep when watchdog enabled.
// R11: watchdog count cleared just before sleep entry; here only while the watchdog enable bit is set.
// R12: system-clocked peripherals disabled during sleep.
// R13: sleep exits on enabled interrupt, any reset, or watchdog time-out.
// R14: sleep wake resumes from the same clock source as before.
// R15: idle stops cpu, system clock and peripherals keep running.
// R16: watchdog count cleared on idle entry.
// R17: low-power rc oscillator runs in idle when watchdog or monitor enabled.
// R18: idle exits on enabled interrupt, any reset, or watchdog time-out.
// R19: idle wake restores cpu clock at once.
// R20: software uses primary oscillator modes for usb, never fast rc pll.
// R21: with fast rc pll, software sets divider to 4 or 8 MHz.
// R22: interrupt during power-save instruction deferred until entry completes.
// R23: reference output held low when disabled, toggles for square wave.
module rcps_top
	import rcps_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                primary_osc_tick,
	input  wire logic                sysclk_tick,
	input  wire logic                power_save_instruction,
	input  wire logic                power_save_operand,
	input  wire logic                wake_irq,
	input  wire logic                wdt_timeout,
	output logic                     ref_clock_pin,
	output rcps_clk_ctl_t            clk_ctl
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic           awr;
		logic [ADDR_W-1:0] awa;
		logic           wr;
		logic [31:0]    wd;
		logic [3:0]     ws;
		logic           bv;
		logic [1:0]     br;
		logic           rv;
		logic [31:0]    rd;
		logic [1:0]     rr;
		logic           awrdy;
		logic           wrdy;
		logic           arrdy;
		logic [15:0]    refctl;
		logic [2:0]     psctl;
		logic [14:0]    div_cnt;
		logic           ref_out;
		rcps_ps_state_t ps;
		logic           ps_mode;
		logic           irq_pend;
		rcps_clk_ctl_t  ctl;
	} rcps_state_t;

	rcps_state_t s_r;
	rcps_state_t s_nxt;

	function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input rcps_state_t s);
		rd_word = 32'h0000_0000;
		case (a[11:0])
			REFCLK_CTRL_OFS: rd_word = {16'h0000, s.refctl};
			PS_CTRL_OFS:     rd_word = {29'h0000_0000, s.psctl};
			PS_STATUS_OFS:   rd_word = {28'h000_0000, s.irq_pend, s.ps_mode, s.ps};
			default:         rd_word = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[11:0] == REFCLK_CTRL_OFS) || (a[11:0] == PS_CTRL_OFS)
			|| (a[11:0] == PS_STATUS_OFS);
	endfunction

	logic        base_tick;
	logic [14:0] half_cnt;
	logic        ref_run;
	logic        wake_ev;

	always_comb begin
		s_nxt = s_r;

		// ----------------------------------------------------------------
		// axi4-lite write: address and data taken in either order
		// ----------------------------------------------------------------
		if (s_axi_awvalid && !s_r.awr && !s_r.bv) begin
			s_nxt.awr = 1'b1;
			s_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.wr && !s_r.bv) begin
			s_nxt.wr = 1'b1;
			s_nxt.wd = s_axi_wdata;
			s_nxt.ws = s_axi_wstrb;
		end
		if (s_r.awr && s_r.wr) begin
			s_nxt.awr = 1'b0;
			s_nxt.wr  = 1'b0;
			s_nxt.bv  = 1'b1;
			s_nxt.br  = mapped(s_r.awa) ? AXI_OKAY : AXI_SLVERR;
			if (s_r.awa[11:0] == REFCLK_CTRL_OFS && s_r.ws[1])
				s_nxt.refctl[15:8] = s_r.wd[15:8] & REFCLK_CTRL_MASK[15:8]; // R6
			if (s_r.awa[11:0] == PS_CTRL_OFS && s_r.ws[0])
				s_nxt.psctl = s_r.wd[2:0];
		end
		if (s_r.bv && s_axi_bready)
			s_nxt.bv = 1'b0;

		// ----------------------------------------------------------------
		// axi4-lite read
		// ----------------------------------------------------------------
		if (s_axi_arvalid && !s_r.rv) begin
			s_nxt.rv = 1'b1;
			s_nxt.rd = rd_word(s_axi_araddr, s_r);
			s_nxt.rr = mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_r.rv && s_axi_rready) begin
			s_nxt.rv = 1'b0;
		end

		// ----------------------------------------------------------------
		// power-save sequencer
		// ----------------------------------------------------------------
		s_nxt.ctl.wdt_clear = 1'b0;
		case (s_r.ps)
			PS_RUN: begin
				if (power_save_instruction) begin // R7
					s_nxt.ps       = PS_ENTER;
					s_nxt.ps_mode  = power_save_operand;
					// a wake event that coincides with the instruction is kept, not dropped
					s_nxt.irq_pend = wake_ev; // R22
				end
			end
			PS_ENTER: begin
				// a wake event here is held until the low-power state is in place
				s_nxt.irq_pend = s_r.irq_pend | wake_ev; // R22
				s_nxt.ps       = PS_LOW;
				s_nxt.ctl.wdt_clear = s_r.psctl[PSC_WDT_EN_BIT] | (s_r.ps_mode == PS_OP_IDLE); // R11 R16
			end
			PS_LOW: begin
				if (wake_ev || s_r.irq_pend) // R13 R18 R22
					s_nxt.ps = PS_WAKE;
				s_nxt.irq_pend = 1'b0;
			end
			PS_WAKE: s_nxt.ps = PS_RUN; // R14 R19
			default: s_nxt.ps = PS_RUN;
		endcase

		s_nxt.ctl.in_sleep = (s_nxt.ps == PS_LOW) && (s_nxt.ps_mode == PS_OP_SLEEP);
		s_nxt.ctl.in_idle  = (s_nxt.ps == PS_LOW) && (s_nxt.ps_mode == PS_OP_IDLE);
		s_nxt.ctl.cpu_clk_en    = (s_nxt.ps != PS_LOW); // R15 R19
		s_nxt.ctl.osc_on        = !s_nxt.ctl.in_sleep; // R8 R14
		s_nxt.ctl.run_clk_en    = !s_nxt.ctl.in_sleep;
		s_nxt.ctl.periph_clk_en = !s_nxt.ctl.in_sleep; // R12 R15
		s_nxt.ctl.fail_safe_clock_monitor_active   = s_r.psctl[PSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT] && !s_nxt.ctl.in_sleep; // R9
		s_nxt.ctl.low_power_rc_osc_on = s_r.psctl[PSC_WDT_EN_BIT]
			|| (s_nxt.ctl.in_idle && s_r.psctl[PSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT]); // R10 R17

		// ----------------------------------------------------------------
		// bus ready flags, registered so that no output has a gate in its path
		// ----------------------------------------------------------------
		s_nxt.awrdy = !s_nxt.awr && !s_nxt.bv;
		s_nxt.wrdy  = !s_nxt.wr && !s_nxt.bv;
		s_nxt.arrdy = !s_nxt.rv;

		// ----------------------------------------------------------------
		// reference clock divider
		// ----------------------------------------------------------------
		// counter restarts while off, so a re-enable begins on a clean low phase
		if (!ref_run) begin
			s_nxt.div_cnt = 15'h0000;
			s_nxt.ref_out = 1'b0; // R23 R1
		end else if (base_tick) begin
			if (s_r.refctl[RDIV_LSB +: 4] == 4'h0) begin
				s_nxt.ref_out = ~s_r.ref_out; // code 0: half base tick rate, fastest possible
			end else if (s_r.div_cnt >= half_cnt - 15'h0001) begin
				s_nxt.div_cnt = 15'h0000;
				s_nxt.ref_out = ~s_r.ref_out; // R2 R23
			end else begin
				s_nxt.div_cnt = s_r.div_cnt + 15'h0001;
			end
		end
	end

	assign wake_ev   = wake_irq | wdt_timeout;
	// base clock is modelled as a tick enable; R3
	assign base_tick = s_r.refctl[RSEL_BIT] ? primary_osc_tick : (sysclk_tick & s_r.ctl.osc_on);
	// toggle every 2^(n-1) base ticks gives period 2^n; R2
	assign half_cnt  = 15'(16'h0001 << (s_r.refctl[RDIV_LSB +: 4] - 4'h1));
	assign ref_run   = s_r.refctl[REF_OUTPUT_ENABLE_BIT]
		&& (!s_r.ctl.in_sleep || (s_r.refctl[RSLP_BIT] && s_r.psctl[PSC_KEEP_PO_BIT])); // R1 R4 R5

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r        <= '0;
			s_r.refctl <= REFCLK_CTRL_RST;
			s_r.psctl  <= PS_CTRL_RST;
			s_r.ps     <= PS_RUN;
			// monitor and low_power_rc_osc start off, matching the power-save control reset
			s_r.ctl    <= 9'b111100000;
			s_r.awrdy  <= 1'b1;
			s_r.wrdy   <= 1'b1;
			s_r.arrdy  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awrdy;
	assign s_axi_wready  = s_r.wrdy;
	assign s_axi_bvalid  = s_r.bv;
	assign s_axi_bresp   = s_r.br;
	assign s_axi_arready = s_r.arrdy;
	assign s_axi_rvalid  = s_r.rv;
	assign s_axi_rdata   = s_r.rd;
	assign s_axi_rresp   = s_r.rr;
	assign ref_clock_pin = s_r.ref_out;
	assign clk_ctl       = s_r.ctl;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ref_low_off: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		!s_r.refctl[REF_OUTPUT_ENABLE_BIT] |=> !ref_clock_pin) else $error("ref pin high while disabled");
	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R6
		(s_r.refctl & ~REFCLK_CTRL_MASK) == 16'h0000) else $error("reserved bits set");
	a_sleep_osc_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		clk_ctl.in_sleep |-> !clk_ctl.osc_on && !clk_ctl.periph_clk_en)
		else $error("clock running in sleep");
	a_sleep_fail_safe_clock_monitor_off: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		clk_ctl.in_sleep |-> !clk_ctl.fail_safe_clock_monitor_active) else $error("monitor active in sleep");
	a_low_power_rc_osc_wdt_on: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		(clk_ctl.in_sleep && $past(s_r.psctl[PSC_WDT_EN_BIT])) |-> clk_ctl.low_power_rc_osc_on)
		else $error("low_power_rc_osc off with watchdog");
	a_idle_wdt_clr: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		(s_r.ps == PS_RUN && power_save_instruction && power_save_operand) |-> ##2 clk_ctl.wdt_clear)
		else $error("no watchdog clear on idle");
	a_idle_cpu_only: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		clk_ctl.in_idle |-> !clk_ctl.cpu_clk_en && clk_ctl.osc_on && clk_ctl.periph_clk_en)
		else $error("idle gating wrong");
	a_wake_bound: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		(s_r.ps == PS_LOW && wdt_timeout) |-> ##2 clk_ctl.cpu_clk_en)
		else $error("no wake on time-out");
	a_defer_irq: assert property (@(posedge aclk) disable iff (!aresetn) // R22
		(s_r.ps == PS_ENTER && wake_irq) |=> s_r.ps == PS_LOW ##1 s_r.ps == PS_WAKE)
		else $error("deferred interrupt lost");

	// ----------------------------------------------------------------
	// register bus checks
	// ----------------------------------------------------------------
	// a held answer must not change under a master that stalls
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready)
		|=> s_axi_bvalid && s_axi_bresp == $past(s_axi_bresp))
		else $error("write response dropped");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready)
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	a_resp_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rd_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid
		|-> !s_axi_arready)
		else $error("read taken while response pending");
	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
		|=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready)
		|=> s_axi_rvalid)
		else $error("read response late");
	a_unmapped_rd: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr))
		|=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	// ----------------------------------------------------------------
	// reference clock checks
	// ----------------------------------------------------------------
	// while running, the pin may only move on a base tick, otherwise glitches reach the far side
	a_ref_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		(ref_run && !base_tick)
		|=> $stable(ref_clock_pin))
		else $error("ref pin moved without base tick");
	a_ref_code0: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		(ref_run && base_tick && s_r.refctl[RDIV_LSB +: 4] == 4'h0)
		|=> ref_clock_pin != $past(ref_clock_pin))
		else $error("ref pin not toggling at code 0");
	a_sleep_ref_stop: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		(s_r.ctl.in_sleep && !s_r.refctl[RSLP_BIT])
		|=> !ref_clock_pin)
		else $error("ref pin running in sleep");

	// ----------------------------------------------------------------
	// power-save checks
	// ----------------------------------------------------------------
	// entry always takes two cycles, so wake events cannot cut it short
	a_run_enter: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		(s_r.ps == PS_RUN && power_save_instruction)
		|=> s_r.ps == PS_ENTER)
		else $error("instruction ignored");
	a_enter_low: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		s_r.ps == PS_ENTER
		|=> s_r.ps == PS_LOW && (clk_ctl.in_sleep || clk_ctl.in_idle))
		else $error("low-power state not reached");
	a_sleep_wdt_clr: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		(s_r.ps == PS_RUN && power_save_instruction && !power_save_operand
		&& s_r.psctl[PSC_WDT_EN_BIT]) |-> ##2 clk_ctl.wdt_clear)
		else $error("no watchdog clear on sleep");
	a_clr_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		clk_ctl.wdt_clear
		|=> !clk_ctl.wdt_clear)
		else $error("watchdog clear longer than a pulse");
	a_wake_irq: assert property (@(posedge aclk) disable iff (!aresetn) // R18
		(s_r.ps == PS_LOW && wake_irq)
		|=> s_r.ps == PS_WAKE)
		else $error("no wake on interrupt");
	a_wake_run: assert property (@(posedge aclk) disable iff (!aresetn) // R19
		s_r.ps == PS_WAKE
		|=> s_r.ps == PS_RUN && clk_ctl.cpu_clk_en && clk_ctl.osc_on)
		else $error("clocks not restored on wake");
	a_defer_entry: assert property (@(posedge aclk) disable iff (!aresetn) // R22
		(s_r.ps == PS_RUN && power_save_instruction && wake_ev)
		|=> s_r.ps == PS_ENTER ##1 s_r.ps == PS_LOW ##1 s_r.ps == PS_WAKE)
		else $error("coincident wake lost");
	a_idle_low_power_rc_osc: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		(clk_ctl.in_idle && $past(s_r.psctl[PSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT]))
		|-> clk_ctl.low_power_rc_osc_on)
		else $error("low_power_rc_osc off in idle with monitor");
	a_idle_fail_safe_clock_monitor: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		(clk_ctl.in_idle && $past(s_r.psctl[PSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT]))
		|-> clk_ctl.fail_safe_clock_monitor_active)
		else $error("monitor stopped in idle");
	a_sleep_run_off: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		clk_ctl.in_sleep
		|-> !clk_ctl.run_clk_en)
		else $error("system clock running in sleep");
	a_idle_osc: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		clk_ctl.in_idle
		|-> clk_ctl.run_clk_en && clk_ctl.osc_on)
		else $error("system clock stopped in idle");
	a_mode_excl: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		clk_ctl.in_sleep
		|-> !clk_ctl.in_idle)
		else $error("sleep and idle together");
	a_cpu_low: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		(clk_ctl.in_sleep || clk_ctl.in_idle)
		|-> !clk_ctl.cpu_clk_en)
		else $error("cpu clocked in low-power state");

endmodule

//--- tb/rcps_ext_dev.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external device clocked from the reference pin
// ----------------------------------------------------------------
module rcps_ext_dev (
	input  wire logic aclk,
	input  wire logic clr,
	input  wire logic ref_in,
	output int        edges
);
	logic last_r;
	// sampled on aclk, so only edges no faster than aclk/2 are seen
	always @(posedge aclk) begin
		last_r <= ref_in;
		if (clr)
			edges <= 0;
		else if (ref_in === 1'b1 && last_r === 1'b0)
			edges <= edges + 1;
	end
endmodule

//--- tb/rcps_top_tb.sv
`timescale 1ns/1ps
module rcps_top_tb;
	import rcps_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic          aclk, aresetn, p_en, s_en, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready;
	logic          s_axi_rvalid, s_axi_rready, primary_osc_tick, sysclk_tick, wake_irq;
	logic          power_save_instruction, power_save_operand, wdt_timeout, ref_clock_pin;
	logic [11:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0]    s_axi_wstrb;
	rcps_clk_ctl_t clk_ctl;
	int            mismatches, tests_run, cyc, wclr, slp_cyc, edges;

	rcps_top uut (.*);
	rcps_ext_dev ext (.aclk(aclk), .clr(clr), .ref_in(ref_clock_pin), .edges(edges));

	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		primary_osc_tick <= p_en;
		sysclk_tick <= s_en;
		cyc <= cyc + 1;
		if (clk_ctl.wdt_clear === 1'b1) wclr <= wclr + 1;
		if (clk_ctl.in_sleep === 1'b1) slp_cyc <= slp_cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end while (!(ad && wd));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask

	function automatic logic [31:0] refw(logic en, logic slp, logic sel, logic [3:0] dv);
		return {16'h0000, en, 1'b0, slp, sel, dv, 8'h00};
	endfunction

	task automatic measure(input int n);
		clr <= 1;
		@(posedge aclk);
		clr <= 0;
		repeat (n) @(posedge aclk);
	endtask

	task automatic ps_go(input logic op, input logic irq);
		power_save_instruction <= 1;
		power_save_operand <= op;
		wake_irq <= irq;
		@(posedge aclk);
		power_save_instruction <= 0;
		wake_irq <= 0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic wake(input logic by_wdt);
		if (by_wdt) wdt_timeout <= 1;
		else wake_irq <= 1;
		@(posedge aclk);
		wdt_timeout <= 0;
		wake_irq <= 0;
		repeat (3) @(posedge aclk);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reg;
		axr(REFCLK_CTRL_OFS);
		chk(rd, 32'h0000_0000, "ref reset");
		axr(PS_STATUS_OFS);
		chk(rd, 32'h0000_0000, "status reset");
		axw(REFCLK_CTRL_OFS, 32'hFFFF_FFFF);
		axr(REFCLK_CTRL_OFS);
		chk(rd, 32'h0000_BF00, "ref unimpl bits");
		axw(12'hFFC, 32'h1);
		chk(rsp, AXI_SLVERR, "unmapped wr");
		axr(12'hFFC);
		chk(rsp, AXI_SLVERR, "unmapped rd");
	endtask

	task automatic t_div;
		int e;
		p_en <= 1;
		for (int c = 0; c < 5; c++) begin
			axw(REFCLK_CTRL_OFS, refw(1, 0, 1, c[3:0]));
			measure(64);
			e = (c == 0) ? 32 : (64 >> c);
			chk(edges >= e - 1 && edges <= e + 1, 1, "divide");
		end
		axw(REFCLK_CTRL_OFS, refw(0, 0, 1, 4'h0));
		measure(16);
		chk(edges == 0 && ref_clock_pin === 1'b0, 1, "disabled low");
	endtask

	task automatic t_src;
		axw(REFCLK_CTRL_OFS, refw(1, 0, 0, 4'h1));
		measure(32);
		chk(edges, 0, "sys base ignores primary");
		p_en <= 0;
		s_en <= 1;
		measure(32);
		chk(edges >= 14 && edges <= 17, 1, "sys base runs");
		s_en <= 0;
	endtask

	task automatic t_sleep;
		int w0;
		axw(REFCLK_CTRL_OFS, 32'h0);
		axw(PS_CTRL_OFS, 32'h3);
		axr(PS_CTRL_OFS);
		chk(rd, 32'h0000_0003, "ps ctrl readback");
		w0 = wclr;
		ps_go(PS_OP_SLEEP, 0);
		chk({clk_ctl.run_clk_en, clk_ctl.osc_on, clk_ctl.cpu_clk_en, clk_ctl.periph_clk_en,
			clk_ctl.fail_safe_clock_monitor_active, clk_ctl.low_power_rc_osc_on, clk_ctl.in_sleep, clk_ctl.in_idle},
			8'b00000110, "sleep");
		chk(wclr - w0, 1, "sleep wdt clear");
		axr(PS_STATUS_OFS);
		chk(rd, 32'h0000_0003, "status in sleep");
		wake(0);
		chk({clk_ctl.cpu_clk_en, clk_ctl.osc_on, clk_ctl.in_sleep}, 3'b110, "sleep wake");
	endtask

	task automatic t_idle;
		int w0;
		axw(PS_CTRL_OFS, 32'h2);
		w0 = wclr;
		ps_go(PS_OP_IDLE, 0);
		chk({clk_ctl.osc_on, clk_ctl.cpu_clk_en, clk_ctl.periph_clk_en, clk_ctl.low_power_rc_osc_on,
			clk_ctl.in_sleep, clk_ctl.in_idle}, 6'b101101, "idle");
		chk(wclr - w0, 1, "idle wdt clear");
		wake(1);
		chk({clk_ctl.cpu_clk_en, clk_ctl.in_idle}, 2'b10, "idle wake");
	endtask

	task automatic t_defer;
		int s0, w0;
		axw(PS_CTRL_OFS, 32'h0);
		s0 = slp_cyc;
		w0 = wclr;
		ps_go(PS_OP_SLEEP, 1);
		repeat (4) @(posedge aclk);
		chk(slp_cyc > s0 && clk_ctl.in_sleep === 1'b0, 1, "deferred wake");
		chk(wclr - w0, 0, "no clear, wdt off");
	endtask

	task automatic t_slp_ref;
		p_en <= 1;
		axw(PS_CTRL_OFS, 32'h4);
		axw(REFCLK_CTRL_OFS, refw(1, 1, 1, 4'h1));
		ps_go(PS_OP_SLEEP, 0);
		measure(32);
		chk(edges >= 15 && edges <= 17, 1, "runs in sleep");
		wake(0);
		axw(REFCLK_CTRL_OFS, refw(1, 0, 1, 4'h1));
		ps_go(PS_OP_SLEEP, 0);
		measure(32);
		chk(edges, 0, "stops in sleep");
		wake(0);
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{aresetn, p_en, s_en, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, power_save_instruction, power_save_operand} = '0;
		{wake_irq, wdt_timeout, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{mismatches, tests_run, cyc, wclr, slp_cyc} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		// stimulus never selects usb clocking or the fast rc pll mode
		t_reg;
		t_div;
		t_src;
		t_sleep;
		t_idle;
		t_defer;
		t_slp_ref;
		print_verdict;
	end
endmodule
